// [core/pct_top.sv]
`timescale 1ns/100ps
module pct_top
  import pct_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pwm_in_a,
  input wire logic pwm_in_b,
  input wire logic tb_zero,
  input wire logic [PCT_NPIN-1:0] trip_input_pin_n,
  output logic pwm_out_a,
  output logic pwm_out_a_oe,
  output logic pwm_out_b,
  output logic pwm_out_b_oe,
  output logic trip_interrupt
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers and state.
  logic [15:0] src_sel_q;
  logic [3:0] act_ctl_q;
  logic [2:0] int_en_q;
  logic [2:0] int_mask_q;
  logic [2:0] flag_q;
  logic [2:0] flag_d;
  logic [10:0] chop_q;
  logic unlock_q;
  logic ack_q;
  logic [2:0] base_q;
  logic [PCT_NPIN-1:0] pin_s;
  logic chop_a;
  logic chop_b;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. One wait cycle on every access keeps read data registered.
  logic req;
  logic wr_go;
  logic lo_be;
  logic hi_be;
  logic sel_src;
  logic sel_act;
  logic sel_ien;
  logic sel_flag;
  logic sel_clr;
  logic sel_frc;
  logic sel_chop;
  logic sel_unl;
  logic sel_msk;
  logic prot_ok;
  logic [15:0] wd;
  logic [15:0] rd_mux;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_go = avs_write & ack_q;
  assign lo_be = avs_byteenable[0];
  assign hi_be = avs_byteenable[1];
  assign wd = avs_writedata[15:0];
  assign sel_src = avs_address == PCT_ADDR_SRC_SEL;
  assign sel_act = avs_address == PCT_ADDR_ACT_CTL;
  assign sel_ien = avs_address == PCT_ADDR_INT_EN;
  assign sel_flag = avs_address == PCT_ADDR_FLAG;
  assign sel_clr = avs_address == PCT_ADDR_CLEAR;
  assign sel_frc = avs_address == PCT_ADDR_FORCE;
  assign sel_chop = avs_address == PCT_ADDR_CHOP;
  assign sel_unl = avs_address == PCT_ADDR_UNLOCK;
  assign sel_msk = avs_address == PCT_ADDR_INT_MASK;
  // Protected writes are dropped silently while locked; the bus still completes.
  assign prot_ok = wr_go & unlock_q;

  // Unmapped addresses read as zero and ignore writes, which keeps stray
  // software from disturbing reserved space.
  assign rd_mux = sel_src ? src_sel_q :
                  sel_act ? {12'h000, act_ctl_q} :
                  sel_ien ? {13'h0000, int_en_q} :
                  sel_flag ? {13'h0000, flag_q} :
                  sel_chop ? {5'h00, chop_q} :
                  sel_unl ? {15'h0000, unlock_q} :
                  sel_msk ? {13'h0000, int_mask_q} : PCT_RST16;

  // Acknowledge toggles so back-to-back requests each get one wait cycle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else if (ce) begin
      ack_q <= req & ~ack_q;
      if (avs_read && !ack_q) begin
        avs_readdata <= {16'h0000, rd_mux};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protection unlock: writing the key opens, anything else closes.
  always_ff @(posedge mclk) begin
    if (reset) begin
      unlock_q <= 1'b0;
    end else if (ce && wr_go && sel_unl && lo_be) begin
      unlock_q <= (wd == PCT_UNLOCK_KEY);
    end
  end

  // Unimplemented select bits stay zero.
  logic [15:0] src_mask;
  assign src_mask = {{(8 - PCT_NPIN){1'b0}}, {PCT_NPIN{1'b1}},
                     {(8 - PCT_NPIN){1'b0}}, {PCT_NPIN{1'b1}}};

  // Configuration registers, with byte enables.
  always_ff @(posedge mclk) begin
    if (reset) begin
      src_sel_q <= PCT_RST16;
      act_ctl_q <= 4'h0;
      int_en_q <= 3'h0;
      int_mask_q <= 3'h0;
      chop_q <= 11'h000;
    end else if (ce) begin
      if (prot_ok && sel_src) begin
        if (lo_be) src_sel_q[7:0] <= wd[7:0] & src_mask[7:0];
        if (hi_be) src_sel_q[15:8] <= wd[15:8] & src_mask[15:8];
      end
      if (prot_ok && sel_act && lo_be) act_ctl_q <= wd[3:0];
      if (prot_ok && sel_ien && lo_be) begin
        int_en_q <= wd[2:0] & {1'b1, 1'b1, 1'b0};
      end
      if (wr_go && sel_msk && lo_be) int_mask_q <= wd[2:0];
      if (wr_go && sel_chop) begin
        if (lo_be) chop_q[7:0] <= wd[7:0];
        if (hi_be) chop_q[10:8] <= wd[10:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip detection.
  logic [PCT_NPIN-1:0] osht_en;
  logic [PCT_NPIN-1:0] cbc_en;
  logic ost_hit;
  logic cbc_hit;
  logic frc_ost;
  logic frc_cbc;
  logic [2:0] clr_bits;
  logic [2:0] set_bits;
  logic tripped;

  assign osht_en = src_sel_q[PCT_OSHT_LSB +: PCT_NPIN];
  assign cbc_en = src_sel_q[PCT_NPIN-1:0];
  assign frc_ost = prot_ok && sel_frc && lo_be && wd[PCT_FLG_OST];
  assign frc_cbc = prot_ok && sel_frc && lo_be && wd[PCT_FLG_CBC];
  assign ost_hit = |(osht_en & ~pin_s) | frc_ost;
  assign cbc_hit = |(cbc_en & ~pin_s) | frc_cbc;
  assign clr_bits = (prot_ok && sel_clr && lo_be) ? wd[2:0] : 3'h0;

  // Set wins over clear. One-shot clears only by software; cycle trip clears
  // at counter zero unless still being driven; interrupt flag by software.
  always_comb begin
    set_bits = 3'h0;
    set_bits[PCT_FLG_OST] = ost_hit;
    set_bits[PCT_FLG_CBC] = cbc_hit;
    set_bits[PCT_FLG_INT] = |((set_bits & ~flag_q) & int_en_q);
    flag_d = flag_q & ~clr_bits;
    if (tb_zero) flag_d[PCT_FLG_CBC] = 1'b0;
    flag_d = flag_d | set_bits;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flag_q <= 3'h0;
    end else if (ce) begin
      flag_q <= flag_d & PCT_FLG_MASK;
    end
  end

  assign tripped = flag_q[PCT_FLG_OST] | flag_q[PCT_FLG_CBC];

  // Level interrupt: each flag bit gated by its software mask bit.
  assign trip_interrupt = |(flag_q & int_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser, chopper base divider and chopper instances.
  pct_sync #(.W(PCT_NPIN)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .async_in(trip_input_pin_n),
    .sync_out(pin_s)
  );

  logic base_tick;
  assign base_tick = base_q == PCT_BASE_LAST;

  // Free-running divide-by-eight of the system clock.
  always_ff @(posedge mclk) begin
    if (reset) begin
      base_q <= 3'h0;
    end else if (ce) begin
      base_q <= base_q + 3'h1;
    end
  end

  logic [1:0] pwm_raw;
  logic [1:0] pwm_chop;
  assign pwm_raw = {pwm_in_b, pwm_in_a};
  assign chop_a = pwm_chop[0];
  assign chop_b = pwm_chop[1];

  // Both outputs share the control fields; one chopper each.
  for (genvar g = 0; g < 2; g++) begin : g_chop
    pct_chopper u_chop (
      .mclk(mclk),
      .reset(reset),
      .ce(ce),
      .base_tick(base_tick),
      .duty_sel(chop_q[PCT_DUTY_LSB +: 3]),
      .freq_div(chop_q[PCT_FREQ_LSB +: 3]),
      .fp_width(chop_q[PCT_FPW_LSB +: 4]),
      .chop_on(chop_q[PCT_CHOP_EN_BIT]),
      .pwm_in(pwm_raw[g]),
      .pwm_out(pwm_chop[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip action: drive level and enable per output, registered.
  logic [1:0] act_a;
  logic [1:0] act_b;
  assign act_a = act_ctl_q[PCT_ACT_A_LSB +: 2];
  assign act_b = act_ctl_q[PCT_ACT_B_LSB +: 2];

  always_ff @(posedge mclk) begin
    if (reset) begin
      pwm_out_a <= 1'b0;
      pwm_out_a_oe <= 1'b1;
      pwm_out_b <= 1'b0;
      pwm_out_b_oe <= 1'b1;
    end else if (ce) begin
      pwm_out_a <= (tripped && act_a == PCT_ACT_HIGH) ? 1'b1 :
                   (tripped && act_a == PCT_ACT_LOW) ? 1'b0 : chop_a;
      pwm_out_a_oe <= !(tripped && act_a == PCT_ACT_HIZ);
      pwm_out_b <= (tripped && act_b == PCT_ACT_HIGH) ? 1'b1 :
                   (tripped && act_b == PCT_ACT_LOW) ? 1'b0 : chop_b;
      pwm_out_b_oe <= !(tripped && act_b == PCT_ACT_HIZ);
    end
  end
endmodule

// [core/pct_pkg.sv]
package pct_pkg;
  // Register byte addresses; the chopper register has no printed offset.
  localparam logic [7:0] PCT_ADDR_SRC_SEL = 8'h24;
  localparam logic [7:0] PCT_ADDR_ACT_CTL = 8'h28;
  localparam logic [7:0] PCT_ADDR_INT_EN = 8'h2a;
  localparam logic [7:0] PCT_ADDR_FLAG = 8'h2c;
  localparam logic [7:0] PCT_ADDR_CLEAR = 8'h2e;
  localparam logic [7:0] PCT_ADDR_FORCE = 8'h30;
  localparam logic [7:0] PCT_ADDR_CHOP = 8'h34;
  localparam logic [7:0] PCT_ADDR_UNLOCK = 8'h38;
  localparam logic [7:0] PCT_ADDR_INT_MASK = 8'h3c;

  // Number of trip pins this instance provides.
  localparam int PCT_NPIN = 2;

  // Chopper field positions, then the one-shot select field position.
  localparam int PCT_DUTY_LSB = 8;
  localparam int PCT_FREQ_LSB = 5;
  localparam int PCT_FPW_LSB = 1;
  localparam int PCT_CHOP_EN_BIT = 0;
  localparam int PCT_OSHT_LSB = 8;

  // Flag register bit positions: interrupt summary, cycle trip, one-shot trip.
  localparam int PCT_FLG_INT = 0;
  localparam int PCT_FLG_CBC = 1;
  localparam int PCT_FLG_OST = 2;

  // Trip action field positions and codes.
  localparam int PCT_ACT_A_LSB = 0;
  localparam int PCT_ACT_B_LSB = 2;
  localparam logic [1:0] PCT_ACT_HIZ = 2'h0;
  localparam logic [1:0] PCT_ACT_HIGH = 2'h1;
  localparam logic [1:0] PCT_ACT_LOW = 2'h2;

  // Chopper base is the system clock divided by eight.
  localparam logic [2:0] PCT_BASE_LAST = 3'h7;
  localparam logic [2:0] PCT_DUTY_RSVD = 3'h7;

  localparam logic [15:0] PCT_RST16 = 16'h0000;
  localparam logic [15:0] PCT_UNLOCK_KEY = 16'h00a5;
  localparam logic [2:0] PCT_FLG_MASK = 3'h7;
endpackage

// [core/pct_sync.sv]
`timescale 1ns/100ps
// Two-stage synchroniser for a bus of asynchronous pins.
module pct_sync
  import pct_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // Pins idle high, so reset to ones to avoid a false trip.
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_q <= '1;
      sync_out <= '1;
    end else if (ce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// [core/pct_chopper.sv]
`timescale 1ns/100ps
// Carrier chopper for one PWM signal.
module pct_chopper
  import pct_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic base_tick,
  input wire logic [2:0] duty_sel,
  input wire logic [2:0] freq_div,
  input wire logic [3:0] fp_width,
  input wire logic chop_on,
  input wire logic pwm_in,
  output logic pwm_out
);
  logic [2:0] div_q;
  logic [2:0] phase_q;
  logic [6:0] fp_q;
  logic fp_act_q;
  logic in_q;
  logic carrier;
  logic rise;

  assign rise = pwm_in & ~in_q;
  // Duty code 7 is reserved; it is treated as 8/8 so nothing hangs.
  assign carrier = (duty_sel == PCT_DUTY_RSVD) ? 1'b1 : (phase_q <= duty_sel);

  // Divider ticks the carrier phase every (code+1) base periods.
  always_ff @(posedge mclk) begin
    if (reset) begin
      div_q <= 3'h0;
      phase_q <= 3'h0;
    end else if (ce && base_tick) begin
      if (div_q >= freq_div) begin
        div_q <= 3'h0;
        phase_q <= phase_q + 3'h1;
      end else begin
        div_q <= div_q + 3'h1;
      end
    end
  end

  // First pulse: (code+1) base periods at full width after each rising edge.
  // It is timed in system clocks from the edge itself, not by the shared base
  // tick, so its width does not depend on where the edge falls in the base cycle.
  // The rise cycle and the final count cycle make up the two missing clocks.
  always_ff @(posedge mclk) begin
    if (reset) begin
      in_q <= 1'b0;
      fp_q <= 4'h0;
      fp_act_q <= 1'b0;
    end else if (ce) begin
      in_q <= pwm_in;
      if (rise) begin
        fp_q <= {fp_width, 3'h6};
        fp_act_q <= 1'b1;
      end else if (!pwm_in) begin
        fp_act_q <= 1'b0;
      end else if (fp_act_q) begin
        if (fp_q == 7'h00) begin
          fp_act_q <= 1'b0;
        end else begin
          fp_q <= fp_q - 7'h01;
        end
      end
    end
  end

  // Bypass when disabled; otherwise first pulse then carrier-gated.
  always_ff @(posedge mclk) begin
    if (reset) begin
      pwm_out <= 1'b0;
    end else if (ce) begin
      pwm_out <= chop_on ? (pwm_in & (rise | fp_act_q | carrier)) : pwm_in;
    end
  end
endmodule

// [verif/pct_top_sva.sv]
`timescale 1ns/100ps
module pct_top_sva
  import pct_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic pwm_in_a,
  input wire logic pwm_in_b,
  input wire logic [PCT_NPIN-1:0] trip_input_pin_n,
  input wire logic pwm_out_a,
  input wire logic pwm_out_a_oe,
  input wire logic pwm_out_b,
  input wire logic pwm_out_b_oe,
  input wire logic trip_interrupt
);
  logic unl_q;
  logic chop_q;
  logic [15:0] sel_q;
  logic [3:0] act_q;
  wire acc_w = avs_write && !avs_waitrequest;
  wire acc_r = avs_read && !avs_waitrequest;
  wire [15:0] wd = avs_writedata[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the registers the checks depend on; only two pins exist, so bits mask.
  always_ff @(posedge mclk) begin
    if (reset) begin
      unl_q <= 1'b0;
      chop_q <= 1'b0;
      sel_q <= 16'h0000;
      act_q <= 4'h0;
    end else if (acc_w) begin
      if (avs_address == PCT_ADDR_UNLOCK) unl_q <= (wd == PCT_UNLOCK_KEY);
      if (avs_address == PCT_ADDR_CHOP) chop_q <= wd[0];
      if (unl_q && avs_address == PCT_ADDR_SRC_SEL) sel_q <= wd & 16'h0303;
      if (unl_q && avs_address == PCT_ADDR_ACT_CTL) act_q <= wd[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync plus flag plus output stage allow up to five edges after three low samples.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_sel_read: assert property (acc_r && avs_address == PCT_ADDR_SRC_SEL |-> avs_readdata == {16'h0000, sel_q})
    else $error("select register readback wrong");
  a_ost_trip: assert property ((sel_q[8] && act_q[1:0] == PCT_ACT_HIGH && !trip_input_pin_n[0]) [*3]
    |-> ##[1:5] (pwm_out_a && pwm_out_a_oe))
    else $error("one-shot trip did not force output a high");
  a_cbc_low: assert property ((sel_q[1] && act_q[3:2] == PCT_ACT_LOW && !trip_input_pin_n[1]) [*3]
    |-> ##[1:5] (!pwm_out_b && pwm_out_b_oe))
    else $error("cycle trip did not force output b low");
  a_cbc_hiz: assert property ((sel_q[1] && act_q[1:0] == PCT_ACT_HIZ && !trip_input_pin_n[1]) [*3]
    |-> ##[1:5] !pwm_out_a_oe)
    else $error("cycle trip did not float output a");
  a_bypass_pass: assert property (sel_q == 16'h0000 && !chop_q && $past(!chop_q)
    |=> pwm_out_a == $past(pwm_in_a, 2) && pwm_out_b == $past(pwm_in_b, 2)
    && pwm_out_a_oe && pwm_out_b_oe)
    else $error("bypass output differs from input");
  a_unmapped_zero: assert property (acc_r && avs_address == 8'h40 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_int_clear: assert property ($fell(trip_interrupt) |-> $past(acc_w))
    else $error("interrupt dropped without a register write");

  cover property ((sel_q[8] && !trip_input_pin_n[0]) [*3]);
  cover property (trip_interrupt);
  cover property (!pwm_out_a_oe);
endmodule

bind pct_top pct_top_sva i_pct_top_sva (
  .mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b),
  .trip_input_pin_n(trip_input_pin_n), .pwm_out_a(pwm_out_a), .pwm_out_a_oe(pwm_out_a_oe),
  .pwm_out_b(pwm_out_b), .pwm_out_b_oe(pwm_out_b_oe), .trip_interrupt(trip_interrupt)
);

// [verif/pct_stage_model.sv]
`timescale 1ns/100ps
module pct_stage_model (
  input wire logic [1:0] fault_req,
  input wire logic pwm_out_a,
  input wire logic pwm_out_a_oe,
  input wire logic pwm_out_b,
  input wire logic pwm_out_b_oe,
  output logic [1:0] trip_input_pin_n,
  output logic gate_a,
  output logic gate_b
);
  // Fault lines are open drain with pull-ups, so a released line reads high.
  assign trip_input_pin_n = ~fault_req;
  // Gate inputs carry pull-downs; a floating output reads low, never a stale level.
  assign gate_a = pwm_out_a_oe ? pwm_out_a : 1'b0;
  assign gate_b = pwm_out_b_oe ? pwm_out_b : 1'b0;
endmodule

// [verif/test_pct_top.sv]
`timescale 1ns/100ps
module test_pct_top
  import pct_pkg::*;
;
  logic mclk, reset, avs_read, avs_write, avs_waitrequest, pwm_in_a, pwm_in_b, tb_zero;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] fault_req, trip_input_pin_n;
  logic pwm_out_a, pwm_out_a_oe, pwm_out_b, pwm_out_b_oe, trip_interrupt, gate_a, gate_b;
  int err_count, n_checks;

  pct_top i_pct_top (.mclk(mclk), .reset(reset), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h3), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pwm_in_a(pwm_in_a), .pwm_in_b(pwm_in_b), .tb_zero(tb_zero),
    .trip_input_pin_n(trip_input_pin_n), .pwm_out_a(pwm_out_a), .pwm_out_a_oe(pwm_out_a_oe),
    .pwm_out_b(pwm_out_b), .pwm_out_b_oe(pwm_out_b_oe), .trip_interrupt(trip_interrupt));
  pct_stage_model i_pct_stage_model (.fault_req(fault_req), .pwm_out_a(pwm_out_a),
    .pwm_out_a_oe(pwm_out_a_oe), .pwm_out_b(pwm_out_b), .pwm_out_b_oe(pwm_out_b_oe),
    .trip_input_pin_n(trip_input_pin_n), .gate_a(gate_a), .gate_b(gate_b));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // The request stands until waitrequest is sampled low; an idle edge follows release.
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a, output logic [15:0] q);
    bus(1'b0, a, 16'h0000, q);
  endtask
  task zero_pulse;
    tb_zero <= 1'b1;
    cyc(1);
    tb_zero <= 1'b0;
    cyc(3);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task t_lock;
    logic [15:0] q;
    rd(PCT_ADDR_SRC_SEL, q);
    chk(q, 16'h0000);
    wr(PCT_ADDR_SRC_SEL, 16'h0101);
    rd(PCT_ADDR_SRC_SEL, q);
    chk(q, 16'h0000);
    wr(PCT_ADDR_UNLOCK, PCT_UNLOCK_KEY);
    wr(PCT_ADDR_SRC_SEL, 16'hffff);
    rd(PCT_ADDR_SRC_SEL, q);
    chk(q, 16'h0303);
    rd(8'h40, q);
    chk(q, 16'h0000);
  endtask
  task t_ost;
    logic [15:0] q;
    wr(PCT_ADDR_ACT_CTL, 16'h0009);
    wr(PCT_ADDR_INT_EN, 16'h0006);
    wr(PCT_ADDR_INT_MASK, 16'h0007);
    wr(PCT_ADDR_SRC_SEL, 16'h0002);
    fault_req <= 2'b01;
    cyc(8);
    chk(gate_a, 1'b0);
    wr(PCT_ADDR_SRC_SEL, 16'h0100);
    cyc(8);
    chk({gate_a, gate_b, trip_interrupt}, 3'b101);
    fault_req <= 2'b00;
    zero_pulse;
    chk({gate_a, gate_b}, 2'b10);
    rd(PCT_ADDR_FLAG, q);
    chk(q[2], 1'b1);
    wr(PCT_ADDR_CLEAR, 16'h0007);
    rd(PCT_ADDR_FLAG, q);
    chk(q, 16'h0000);
    chk({trip_interrupt, gate_a, pwm_out_a_oe}, 3'b001);
  endtask
  task t_cbc;
    logic [15:0] q;
    wr(PCT_ADDR_ACT_CTL, 16'h0008);
    wr(PCT_ADDR_SRC_SEL, 16'h0002);
    fault_req <= 2'b10;
    cyc(8);
    chk({pwm_out_a_oe, pwm_out_b, pwm_out_b_oe}, 3'b001);
    chk(trip_interrupt, 1'b1);
    rd(PCT_ADDR_FLAG, q);
    chk(q[1], 1'b1);
    fault_req <= 2'b00;
    cyc(6);
    chk(pwm_out_a_oe, 1'b0);
    zero_pulse;
    chk(pwm_out_a_oe, 1'b1);
    wr(PCT_ADDR_CLEAR, 16'h0007);
    wr(PCT_ADDR_SRC_SEL, 16'h0000);
  endtask
  // Duty 3, divide 2, first pulse 2 base periods: 16 clocks of first pulse, then a
  // 128-clock carrier with 64 clocks high; the carrier phase is free running.
  task t_chop;
    int n;
    pwm_in_a <= 1'b1;
    cyc(3);
    chk({gate_a, gate_b}, 2'b10);
    pwm_in_a <= 1'b0;
    cyc(2);
    wr(PCT_ADDR_CHOP, 16'h0323);
    pwm_in_a <= 1'b1;
    cyc(2);
    n = 0;
    repeat (16) begin
      cyc(1);
      if (gate_a === 1'b1) n++;
    end
    chk(n[15:0], 16'h0010);
    n = 0;
    repeat (128) begin
      cyc(1);
      if (gate_a === 1'b1) n++;
    end
    chk(n[15:0], 16'h0040);
    pwm_in_a <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, main sequence and a watchdog well beyond the few hundred cycles needed.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    reset = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    pwm_in_a = 1'b0;
    pwm_in_b = 1'b0;
    tb_zero = 1'b0;
    fault_req = 2'b00;
    err_count = 0;
    n_checks = 0;
    cyc(10);
    reset <= 1'b0;
    t_lock;
    t_ost;
    t_cbc;
    t_chop;
    finish_test;
  end
  initial begin
    #150000;
    err_count++;
    finish_test;
  end
endmodule
